//--- rtl/pwd_dma.sv
/*
 Parallel word DMA interface: register file, user handshake, counters,
 and the host bus master sequencer.
 Assumes all inputs are synchronous to mclk_i and the register port presents
 one access per strobe cycle.
*/
`timescale 1ns/1ps
`include "pwd_defines.svh"
module pwd_dma #(
   parameter int ADDR_BITS = 18,
   parameter int NXM_CYCLES = `PWD_NXM_CYCLES
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic resetn_i,
   // Register port
   input wire logic [1:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [1:0] reg_be_i,
   input wire logic [15:0] reg_wdata_i,
   output logic [15:0] reg_rdata_o,
   output logic irq_o,
   // User device
   input wire logic [15:0] data_in_i,
   output logic [15:0] data_out_o,
   input wire logic cycle_request_i,
   input wire logic [1:0] cycle_type_select_i,
   input wire logic single_cycle_i,
   input wire logic byte_address_low_i,
   input wire logic count_advance_enable_i,
   input wire logic address_advance_enable_i,
   input wire logic attention_abort_i,
   input wire logic [2:0] status_i,
   output logic [2:0] function_o,
   output logic busy_o,
   output logic ready_o,
   // Host bus master
   output logic dma_req_o,
   input wire logic dma_grant_i,
   output logic bus_ack_o,
   output logic bus_strobe_o,
   output logic bus_write_o,
   output logic bus_byte_o,
   output logic [17:0] bus_addr_o,
   output logic [15:0] bus_wdata_o,
   input wire logic [15:0] bus_rdata_i,
   input wire logic bus_reply_i
);
   // ---------------------------------------------------------------------------
   // State
   // ---------------------------------------------------------------------------
   logic [15:0] word_count;
   logic [14:0] bus_address_counter;
   logic [1:0] ext_addr;
   logic [2:0] func;
   logic int_enable;
   logic ready;
   logic cycle_pending;
   logic maint;
   logic nxm;
   logic [15:0] output_data_buffer;
   logic [15:0] input_data_buffer;
   pwd_pkg::pwd_user_ctl_t ctl;

   logic [15:0] csr_view;
   logic [15:0] csr_wr;
   logic wr_word;
   logic wr_csr;
   logic go;
   logic prog_start;
   logic req_pulse;
   logic accept;
   logic start;
   logic done;
   logic nxm_pulse;
   logic [15:0] rdata;
   logic [15:0] next_word_count;
   logic [16:0] next_address;
   logic [17:0] full_addr;
   logic [17:0] eff_addr;
   pwd_pkg::pwd_bus_cmd_t cmd;

   // Byte-lane merge of a write into an old value
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                         input logic [1:0] be);
      merge = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
   endfunction

   // ---------------------------------------------------------------------------
   // Register decode
   // ---------------------------------------------------------------------------
   assign wr_word = reg_wr_i && (reg_be_i == 2'h3);
   assign wr_csr = reg_wr_i && (reg_addr_i == `PWD_IDX_CONTROL);
   assign csr_wr = merge(csr_view, reg_wdata_i, reg_be_i);
   assign go = wr_csr && reg_be_i[0] && reg_wdata_i[`PWD_CSR_GO];
   assign prog_start = wr_csr && reg_be_i[1] && reg_wdata_i[`PWD_CSR_CYCLE] &&
                       !ready && !cycle_pending;

   assign csr_view = {nxm | attention_abort_i, nxm, attention_abort_i, maint, status_i,
                      cycle_pending, ready, int_enable, ext_addr, func, 1'b0};

   // ---------------------------------------------------------------------------
   // User request
   // ---------------------------------------------------------------------------
   pwd_rise u_req_edge (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .level_i(cycle_request_i),
      .pulse_o(req_pulse)
   );

   assign accept = req_pulse && !ready && !cycle_pending;
   assign start = accept || prog_start;

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         input_data_buffer <= 16'h0000;
         ctl <= '0;
      end else if (start) begin
         input_data_buffer <= data_in_i;
         ctl <= {pwd_pkg::pwd_cycle_t'(cycle_type_select_i), single_cycle_i, byte_address_low_i,
                 count_advance_enable_i, address_advance_enable_i};
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cycle_pending <= 1'b0;
      end else if (start) begin
         cycle_pending <= 1'b1;
      end else if (done || nxm_pulse) begin
         cycle_pending <= 1'b0;
      end
   end

   // ---------------------------------------------------------------------------
   // Counters
   // ---------------------------------------------------------------------------
   assign next_word_count = word_count + 16'h0001;
   assign next_address = {ext_addr, bus_address_counter} + 17'h00001;

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         word_count <= 16'h0000;
      end else if (done && ctl.count_advance_enable) begin
         word_count <= next_word_count;
      end else if (wr_word && reg_addr_i == `PWD_IDX_WORD_COUNT) begin
         word_count <= reg_wdata_i;
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         bus_address_counter <= 15'h0000;
         ext_addr <= 2'h0;
      end else if (done && ctl.address_advance_enable) begin
         {ext_addr, bus_address_counter} <= next_address;
      end else begin
         if (wr_word && reg_addr_i == `PWD_IDX_ADDRESS) begin
            bus_address_counter <= reg_wdata_i[15:1];
         end
         if (wr_csr) begin
            ext_addr <= csr_wr[`PWD_CSR_EXT_LSB+1:`PWD_CSR_EXT_LSB];
         end
      end
   end

   // ---------------------------------------------------------------------------
   // Control/status
   // ---------------------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         func <= 3'h0;
         int_enable <= 1'b0;
         maint <= 1'b0;
      end else if (wr_csr) begin
         func <= csr_wr[`PWD_CSR_FUNC_LSB+2:`PWD_CSR_FUNC_LSB];
         int_enable <= csr_wr[`PWD_CSR_IE];
         maint <= csr_wr[`PWD_CSR_MAINT];
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         nxm <= 1'b0;
      end else if (nxm_pulse) begin
         nxm <= 1'b1;
      end else if (wr_csr && reg_be_i[1] && !reg_wdata_i[`PWD_CSR_NXM]) begin
         nxm <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ready <= 1'(`PWD_CSR_RESET >> `PWD_CSR_READY);
      end else if (nxm_pulse || attention_abort_i) begin
         ready <= 1'b1;
      end else if (done && ctl.count_advance_enable && next_word_count == 16'h0000) begin
         ready <= 1'b1;
      end else if (go) begin
         ready <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= int_enable && (ready || nxm);
      end
   end

   // ---------------------------------------------------------------------------
   // Data buffers
   // ---------------------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         output_data_buffer <= 16'h0000;
      end else if (done && (ctl.cycle == pwd_pkg::PWD_READ || ctl.cycle == pwd_pkg::PWD_RMW)) begin
         output_data_buffer <= rdata;
      end else if (reg_wr_i && reg_addr_i == `PWD_IDX_DATA) begin
         output_data_buffer <= merge(output_data_buffer, reg_wdata_i, reg_be_i);
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         reg_rdata_o <= 16'h0000;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            `PWD_IDX_WORD_COUNT: reg_rdata_o <= word_count;
            `PWD_IDX_ADDRESS: reg_rdata_o <= {bus_address_counter, 1'b0};
            `PWD_IDX_CONTROL: reg_rdata_o <= csr_view;
            default: reg_rdata_o <= input_data_buffer;
         endcase
      end
   end

   // ---------------------------------------------------------------------------
   // Bus master
   // ---------------------------------------------------------------------------
   assign full_addr = {ext_addr, bus_address_counter,
                       (ctl.cycle == pwd_pkg::PWD_WRITE_BYTE) ? ctl.byte_address_low : 1'b0};
   always_comb begin
      for (int i = 0; i < 18; i++) begin
         eff_addr[i] = (i < ADDR_BITS) ? full_addr[i] : 1'b0;
      end
   end

   always_comb begin
      cmd.cycle = pwd_pkg::pwd_cycle_t'(cycle_type_select_i);
      cmd.addr = eff_addr;
      cmd.wdata = data_in_i;
      if (!start) begin
         cmd.cycle = ctl.cycle;
         cmd.wdata = input_data_buffer;
      end
   end

   pwd_bus_master #(
      .NXM_CYCLES(NXM_CYCLES)
   ) u_master (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .start_i(cycle_pending && !done && !nxm_pulse && !bus_strobe_o && !dma_req_o),
      .hold_i(!ctl.single_cycle && !ready),
      .cmd_i(cmd),
      .done_o(done),
      .nxm_o(nxm_pulse),
      .rdata_o(rdata),
      .dma_req_o(dma_req_o),
      .dma_grant_i(dma_grant_i),
      .bus_ack_o(bus_ack_o),
      .bus_strobe_o(bus_strobe_o),
      .bus_write_o(bus_write_o),
      .bus_byte_o(bus_byte_o),
      .bus_addr_o(bus_addr_o),
      .bus_wdata_o(bus_wdata_o),
      .bus_rdata_i(bus_rdata_i),
      .bus_reply_i(bus_reply_i)
   );

   assign busy_o = !cycle_pending;
   assign ready_o = ready;
   assign data_out_o = output_data_buffer;
   assign function_o = func;
endmodule // pwd_dma

//--- rtl/pwd_defines.svh
/*
 Register indices, control/status field positions, reset values and timing counts
 for the parallel word DMA interface.
 Assumes a 100 MHz mclk_i.
*/
// Contract
// - Word count is 16-bit read/write, loaded with minus the count, word access only.
// - Word count advances each transfer; at zero transfers stop, ready sets, interrupt requested.
// - Address counter is 15-bit read/write word address, word access only.
// - Address counter advances each transfer and carries into the extended address bits.
// - With a 16-bit address space the extended bits drop and the address wraps.
// - Control/status bit 0 is write-only and always reads zero.
// - Bits 0-6, 8, 12 are read/write; bits 7, 9-11, 13-15 read-only.
// - Control/status bit 14 clears on a written zero; a written one does nothing.
// - Bits 4 and 5 are extended address bits; byte and word access allowed.
// - Input buffer read-only from user; output buffer write-only to user; DMA or program.
// - Both buffers share one address: reads input, writes output; byte or word.
// - Writing one to the start bit drives ready low, allowing transfers.
// - A transfer request latches input data, cycle type and burst select.
// - A transfer request sets the pending-cycle flag, which requests bus mastership.
// - Burst select idles high for single cycles; driven low selects burst.
// - Sixteen active-high data outputs and sixteen active-high data inputs.
// - Attention input high ends transfers, sets ready, requests interrupt if enabled.
// - Either advance enable low suppresses advancing its counter after the transfer.
// - After a transfer not reaching zero: advance counters, busy high, ready stays low.
// - No memory reply marks nonexistent memory and raises a special-condition interrupt.
`ifndef PWD_DEFINES_SVH
`define PWD_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register indices on the register port
// ----------------------------------------------------------------------------
`define PWD_IDX_WORD_COUNT 2'h0
`define PWD_IDX_ADDRESS 2'h1
`define PWD_IDX_CONTROL 2'h2
`define PWD_IDX_DATA 2'h3

// ----------------------------------------------------------------------------
// Control/status fields
// ----------------------------------------------------------------------------
`define PWD_CSR_GO 0
`define PWD_CSR_FUNC_LSB 1
`define PWD_CSR_EXT_LSB 4
`define PWD_CSR_IE 6
`define PWD_CSR_READY 7
`define PWD_CSR_CYCLE 8
`define PWD_CSR_STAT_LSB 9
`define PWD_CSR_MAINT 12
`define PWD_CSR_ATTENTION_ABORT 13
`define PWD_CSR_NXM 14
`define PWD_CSR_SPECIAL 15
`define PWD_CSR_RESET 16'h0080

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PWD_CLK_PERIOD_NS 10
`define PWD_NXM_TIME_NS 10000
`define PWD_NXM_CYCLES ((`PWD_NXM_TIME_NS + `PWD_CLK_PERIOD_NS - 1) / `PWD_CLK_PERIOD_NS)

`endif

//--- rtl/pwd_pkg.sv
/*
 Types shared by the parallel word DMA interface modules.
 Assumes nothing of its surroundings.
*/
package pwd_pkg;
   // Bus cycle type, code is {first select line, second select line}
   typedef enum logic [1:0] {
      PWD_READ = 2'b00,
      PWD_WRITE = 2'b01,
      PWD_RMW = 2'b10,
      PWD_WRITE_BYTE = 2'b11
   } pwd_cycle_t;

   typedef struct packed {
      pwd_cycle_t cycle;
      logic single_cycle;
      logic byte_address_low;
      logic count_advance_enable;
      logic address_advance_enable;
   } pwd_user_ctl_t;

   typedef struct packed {
      pwd_cycle_t cycle;
      logic [17:0] addr;
      logic [15:0] wdata;
   } pwd_bus_cmd_t;

   typedef enum logic [2:0] {
      PWD_M_IDLE = 3'b000,
      PWD_M_REQ = 3'b001,
      PWD_M_READ = 3'b010,
      PWD_M_RD_END = 3'b011,
      PWD_M_WRITE = 3'b100,
      PWD_M_WR_END = 3'b101
   } pwd_mstate_t;
endpackage

//--- rtl/pwd_rise.sv
/*
 Rising edge detector giving a one-cycle pulse.
 Assumes the input is synchronous to mclk_i.
*/
`timescale 1ns/1ps
module pwd_rise (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic resetn_i,
   // Level in, pulse out
   input wire logic level_i,
   output logic pulse_o
);
   logic prev;

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         prev <= 1'b0;
      end else begin
         prev <= level_i;
      end
   end

   assign pulse_o = level_i & ~prev;
endmodule // pwd_rise

//--- rtl/pwd_bus_master.sv
/*
 Host bus master sequencer: requests mastership, runs a read and/or write phase,
 and times out a missing reply.
 Assumes the host arbiter answers dma_req_o with dma_grant_i and memory answers
 bus_strobe_o with bus_reply_i, all synchronous to mclk_i.
*/
`timescale 1ns/1ps
`include "pwd_defines.svh"
module pwd_bus_master #(
   parameter int NXM_CYCLES = `PWD_NXM_CYCLES
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic resetn_i,
   // Command side
   input wire logic start_i,
   input wire logic hold_i,
   input wire pwd_pkg::pwd_bus_cmd_t cmd_i,
   output logic done_o,
   output logic nxm_o,
   output logic [15:0] rdata_o,
   // Host bus side
   output logic dma_req_o,
   input wire logic dma_grant_i,
   output logic bus_ack_o,
   output logic bus_strobe_o,
   output logic bus_write_o,
   output logic bus_byte_o,
   output logic [17:0] bus_addr_o,
   output logic [15:0] bus_wdata_o,
   input wire logic [15:0] bus_rdata_i,
   input wire logic bus_reply_i
);
   pwd_pkg::pwd_mstate_t state;
   pwd_pkg::pwd_mstate_t first_phase;
   pwd_pkg::pwd_bus_cmd_t cmd;
   logic [15:0] timer;
   logic timeout;

   assign first_phase = (cmd.cycle == pwd_pkg::PWD_READ || cmd.cycle == pwd_pkg::PWD_RMW) ?
                        pwd_pkg::PWD_M_READ : pwd_pkg::PWD_M_WRITE;
   assign timeout = (timer == 16'(NXM_CYCLES - 1));

   // ---------------------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state <= pwd_pkg::PWD_M_IDLE;
      end else begin
         case (state)
            pwd_pkg::PWD_M_IDLE: begin
               if (start_i) begin
                  state <= pwd_pkg::PWD_M_REQ;
               end
            end
            pwd_pkg::PWD_M_REQ: begin
               if (dma_grant_i || bus_ack_o) begin
                  state <= first_phase;
               end
            end
            pwd_pkg::PWD_M_READ: begin
               if (bus_reply_i) begin
                  state <= pwd_pkg::PWD_M_RD_END;
               end else if (timeout) begin
                  state <= pwd_pkg::PWD_M_IDLE;
               end
            end
            pwd_pkg::PWD_M_RD_END: begin
               if (!bus_reply_i) begin
                  state <= (cmd.cycle == pwd_pkg::PWD_RMW) ? pwd_pkg::PWD_M_WRITE :
                           pwd_pkg::PWD_M_IDLE;
               end
            end
            pwd_pkg::PWD_M_WRITE: begin
               if (bus_reply_i) begin
                  state <= pwd_pkg::PWD_M_WR_END;
               end else if (timeout) begin
                  state <= pwd_pkg::PWD_M_IDLE;
               end
            end
            pwd_pkg::PWD_M_WR_END: begin
               if (!bus_reply_i) begin
                  state <= pwd_pkg::PWD_M_IDLE;
               end
            end
            default: begin
               state <= pwd_pkg::PWD_M_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------------------
   // Command hold, reply timer, read data, completion pulses
   // ---------------------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cmd <= '0;
      end else if (start_i && state == pwd_pkg::PWD_M_IDLE) begin
         cmd <= cmd_i;
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         timer <= 16'h0000;
      end else if (bus_strobe_o && !bus_reply_i) begin
         timer <= timer + 16'h0001;
      end else begin
         timer <= 16'h0000;
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_o <= 16'h0000;
      end else if (state == pwd_pkg::PWD_M_READ && bus_reply_i) begin
         rdata_o <= bus_rdata_i;
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         done_o <= 1'b0;
         nxm_o <= 1'b0;
      end else begin
         done_o <= !bus_reply_i && (state == pwd_pkg::PWD_M_WR_END ||
                   (state == pwd_pkg::PWD_M_RD_END && cmd.cycle != pwd_pkg::PWD_RMW));
         nxm_o <= timeout && !bus_reply_i && bus_strobe_o;
      end
   end

   // Mastership is kept between cycles in burst mode
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         bus_ack_o <= 1'b0;
      end else if (state == pwd_pkg::PWD_M_REQ && dma_grant_i) begin
         bus_ack_o <= 1'b1;
      end else if (state == pwd_pkg::PWD_M_IDLE && !hold_i) begin
         bus_ack_o <= 1'b0;
      end
   end

   assign dma_req_o = (state == pwd_pkg::PWD_M_REQ) && !bus_ack_o;
   assign bus_strobe_o = (state == pwd_pkg::PWD_M_READ) || (state == pwd_pkg::PWD_M_WRITE);
   assign bus_write_o = (state == pwd_pkg::PWD_M_WRITE) || (state == pwd_pkg::PWD_M_WR_END);
   assign bus_byte_o = (cmd.cycle == pwd_pkg::PWD_WRITE_BYTE);
   assign bus_addr_o = cmd.addr;
   assign bus_wdata_o = cmd.wdata;
endmodule // pwd_bus_master

//--- test/pwd_dma_asserts.sv
/* Port checker for pwd_dma.
   Bound to every pwd_dma; timeout bounds assume NXM_CYCLES near 20. */
`timescale 1ns/1ps
module pwd_dma_asserts (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic resetn_i,
   // Observed ports
   input wire logic [1:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [1:0] reg_be_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic [15:0] reg_rdata_o,
   input wire logic cycle_request_i,
   input wire logic attention_abort_i,
   input wire logic busy_o,
   input wire logic ready_o,
   input wire logic dma_req_o,
   input wire logic bus_strobe_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);
   sequence s_take;
      $rose(cycle_request_i) && !ready_o && busy_o;
   endsequence
   sequence s_csr_read;
      reg_rd_i && reg_addr_i == 2'h2;
   endsequence
   a_go_drops_ready: assert property (reg_wr_i && reg_addr_i == 2'h2 && reg_be_i[0]
      && reg_wdata_i[0] && !attention_abort_i |=> !ready_o) else $error("ready stayed high");
   a_go_reads_zero: assert property (s_csr_read |=> !reg_rdata_o[0])
      else $error("go bit read as one");
   a_ready_bit_seen: assert property (s_csr_read |=> reg_rdata_o[7] == $past(ready_o))
      else $error("ready bit mismatch");
   a_take_busy: assert property (s_take |=> !busy_o) else $error("busy did not fall");
   a_req_follows: assert property (s_take ##1 !busy_o |=> dma_req_o)
      else $error("no bus request");
   a_busy_in_cycle: assert property (bus_strobe_o |-> !busy_o)
      else $error("busy high in cycle");
   a_cycle_ends: assert property (s_take |-> ##[2:80] $rose(busy_o))
      else $error("cycle never ended");
   a_strobe_bounded: assert property ($rose(bus_strobe_o) |-> ##[1:40] !bus_strobe_o)
      else $error("strobe never dropped");
   a_attention_abort_sets_ready: assert property ($rose(attention_abort_i) |-> ##[1:3] ready_o)
      else $error("attention ignored");
endmodule // pwd_dma_asserts
bind pwd_dma pwd_dma_asserts i_pwd_dma_asserts (.*);

//--- test/pwd_mem_model.sv
/* Host arbiter and memory model facing the bus master of pwd_dma.
   Read data is an address pattern; mute_i withholds every reply. */
`timescale 1ns/1ps
module pwd_mem_model (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic resetn_i,
   // Bus from the block, and mute_i from the bench
   input wire logic dma_req_o,
   input wire logic bus_strobe_o,
   input wire logic bus_write_o,
   input wire logic [17:0] bus_addr_o,
   input wire logic [15:0] bus_wdata_o,
   input wire logic mute_i,
   // Answers
   output logic dma_grant_i,
   output logic bus_reply_i,
   output logic [15:0] bus_rdata_i
);
   logic [17:0] last_addr;
   logic [15:0] last_data;
   logic [1:0] wait_cnt;
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         dma_grant_i <= 1'b0;
         bus_reply_i <= 1'b0;
         wait_cnt <= 2'h0;
         bus_rdata_i <= 16'h0;
      end else begin
         dma_grant_i <= dma_req_o;
         wait_cnt <= (bus_strobe_o && wait_cnt != 2'h3) ? wait_cnt + 2'h1 : wait_cnt;
         // Latency varies with the address so slow and prompt replies both occur
         bus_reply_i <= bus_strobe_o && !mute_i && wait_cnt >= bus_addr_o[2:1];
         // Undriven data toggles so a stale value never looks valid
         bus_rdata_i <= (bus_strobe_o && !bus_write_o) ? bus_addr_o[15:0] ^ 16'h5a5a : ~bus_rdata_i;
         if (!bus_strobe_o) wait_cnt <= 2'h0;
         if (bus_strobe_o && bus_write_o && !mute_i) begin
            last_addr <= bus_addr_o;
            last_data <= bus_wdata_o;
         end
      end
   end
endmodule // pwd_mem_model

//--- test/pwd_dma_tb.sv
/* Self-checking bench for pwd_dma with the memory model on its bus.
   Assumes pwd_dma_asserts is bound by its own file. */
`timescale 1ns/1ps
module pwd_dma_tb;
   logic mclk_i = 1'b0, resetn_i = 1'b0, reg_wr_i, reg_rd_i, cycle_request_i, single_cycle_i;
   logic byte_address_low_i, mute_i, count_advance_enable_i, address_advance_enable_i, bal;
   logic attention_abort_i, dma_grant_i, irq_o, busy_o, ready_o, dma_req_o, bus_ack_o;
   logic bus_strobe_o, bus_write_o, bus_byte_o, bus_reply_i;
   logic [1:0] reg_addr_i, reg_be_i, cycle_type_select_i, ct;
   logic [2:0] status_i, function_o;
   logic [15:0] reg_wdata_i, reg_rdata_o, data_in_i, data_out_o, bus_wdata_o, bus_rdata_i, rv, x;
   logic [15:0] din;
   logic [17:0] bus_addr_o, ea;
   int bad_count = 0;
   int compares = 0;
   pwd_dma #(.NXM_CYCLES(20)) i_pwd_dma (.*);
   pwd_mem_model i_pwd_mem_model (.*);
   always #5 mclk_i = ~mclk_i;
   task automatic tally_and_finish();
      if (bad_count == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic [1:0] a, input logic w, input logic [1:0] be,
                      input logic [15:0] d);
      reg_addr_i <= a;
      reg_wr_i <= w;
      reg_rd_i <= !w;
      reg_be_i <= be;
      reg_wdata_i <= d;
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
      reg_rd_i <= 1'b0;
      @(posedge mclk_i);
      rv = reg_rdata_o;
   endtask
   task automatic wait_busy(input logic want);
      int n;
      n = 0;
      while (busy_o !== want && n < 200) begin
         @(posedge mclk_i);
         n++;
      end
      if (busy_o !== want) begin
         bad_count++;
         $display("BAD %0t busy timeout", $time);
         tally_and_finish();
      end
   endtask
   task automatic xfer(input logic [1:0] t, input logic b);
      din = 16'($urandom);
      data_in_i <= din;
      cycle_type_select_i <= t;
      byte_address_low_i <= b;
      @(posedge mclk_i);
      cycle_request_i <= 1'b1;
      @(posedge mclk_i);
      wait_busy(1'b0);
      wait_busy(1'b1);
      cycle_request_i <= 1'b0;
      @(posedge mclk_i);
   endtask
   initial begin
      {reg_wr_i, reg_rd_i, cycle_request_i, attention_abort_i, mute_i} = 5'h0;
      {single_cycle_i, count_advance_enable_i, address_advance_enable_i} = 3'h7;
      {reg_addr_i, reg_be_i, cycle_type_select_i, reg_wdata_i, data_in_i} = 22'h0;
      byte_address_low_i = 1'b1;
      status_i = 3'h5;
      void'($urandom(82));
      repeat (16) @(posedge mclk_i);
      resetn_i <= 1'b1;
      @(posedge mclk_i);
      x = 16'($urandom);
      acc(2'h0, 1'b1, 2'h3, x);
      acc(2'h0, 1'b1, 2'h1, ~x);
      acc(2'h0, 1'b0, 2'h3, 16'h0);
      chk(rv, x);
      acc(2'h1, 1'b1, 2'h3, x);
      acc(2'h1, 1'b0, 2'h3, 16'h0);
      chk(rv, {x[15:1], 1'b0});
      acc(2'h2, 1'b1, 2'h3, 16'h7efe);
      acc(2'h2, 1'b0, 2'h3, 16'h0);
      chk(rv, 16'h1afe);
      chk(function_o, 18'h7);
      acc(2'h2, 1'b1, 2'h1, 16'h0);
      acc(2'h2, 1'b0, 2'h3, 16'h0);
      chk(rv, 16'h1a80);
      acc(2'h3, 1'b1, 2'h3, x);
      chk(data_out_o, x);
      acc(2'h0, 1'b1, 2'h3, 16'hfffc);
      acc(2'h1, 1'b1, 2'h3, 16'hfffc);
      acc(2'h2, 1'b1, 2'h3, 16'h0041);
      chk(ready_o, 18'h0);
      for (int k = 0; k < 4; k++) begin
         ct = (k == 0) ? 2'h1 : (k == 1) ? 2'h3 : (k == 2) ? 2'h0 : 2'h2;
         bal = (ct == 2'h3) ? 1'($urandom) : 1'b1;
         xfer(ct, bal);
         ea = 18'h0fffc + 18'(2 * k) + ((ct == 2'h3) ? 18'(bal) : 18'h0);
         if (ct != 2'h0) chk(i_pwd_mem_model.last_addr, ea);
         if (ct[1] ^ ct[0]) chk(i_pwd_mem_model.last_data, din);
         if (!ct[0]) chk(data_out_o, ea[15:0] ^ 16'h5a5a);
         chk(bus_byte_o, 18'(ct == 2'h3));
         chk(ready_o, 18'(k == 3));
      end
      acc(2'h3, 1'b0, 2'h3, 16'h0);
      chk(rv, din);
      acc(2'h1, 1'b0, 2'h3, 16'h0);
      chk(rv, 16'h0004);
      acc(2'h2, 1'b0, 2'h3, 16'h0);
      chk(rv[5:4], 18'h1);
      chk(irq_o, 18'h1);
      acc(2'h0, 1'b1, 2'h3, 16'hfffe);
      acc(2'h2, 1'b1, 2'h1, 16'h0001);
      count_advance_enable_i <= 1'b0;
      address_advance_enable_i <= 1'b0;
      single_cycle_i <= 1'b0;
      xfer(2'h1, 1'b1);
      chk(ready_o, 18'h0);
      chk(bus_ack_o, 18'h1);
      acc(2'h0, 1'b0, 2'h3, 16'h0);
      chk(rv, 16'hfffe);
      acc(2'h1, 1'b0, 2'h3, 16'h0);
      chk(rv, 16'h0004);
      attention_abort_i <= 1'b1;
      single_cycle_i <= 1'b1;
      acc(2'h2, 1'b0, 2'h3, 16'h0);
      chk(ready_o, 18'h1);
      chk(rv[15:13], 18'h5);
      chk(irq_o, 18'h0);
      attention_abort_i <= 1'b0;
      acc(2'h2, 1'b1, 2'h3, 16'h0041);
      mute_i <= 1'b1;
      xfer(2'h1, 1'b1);
      chk(ready_o, 18'h1);
      mute_i <= 1'b0;
      acc(2'h2, 1'b1, 2'h2, 16'h4000);
      acc(2'h2, 1'b0, 2'h3, 16'h0);
      chk(rv[15:14], 18'h3);
      chk(irq_o, 18'h1);
      acc(2'h2, 1'b1, 2'h2, 16'h0);
      acc(2'h2, 1'b0, 2'h3, 16'h0);
      chk(rv[14], 18'h0);
      tally_and_finish();
   end
endmodule // pwd_dma_tb
